// File: include/pdim_pkg.sv
// pdim_pkg: offsets, field positions, reset values and widths for the
// power-down and input-monitor register bank; assumes 8-bit register access.
package pdim_pkg;
  // register offsets
  localparam logic [7:0] INPUT_REFERENCE_DISABLE_OFS = 8'hb5;
  localparam logic [7:0] OUTPUT_DRIVER_DISABLE_OFS = 8'hb7;
  localparam logic [7:0] PLL_BLOCK_DISABLE_OFS = 8'hb8;
  localparam logic [7:0] INPUT0_LOS_COUNT_HIGH_OFS = 8'hb9;
  localparam logic [7:0] INPUT0_LOS_COUNT_MID_OFS = 8'hba;
  localparam logic [7:0] INPUT0_LOS_COUNT_LOW_OFS = 8'hbb;
  localparam logic [7:0] INPUT1_LOS_COUNT_HIGH_OFS = 8'hbc;
  localparam logic [7:0] INPUT1_LOS_COUNT_MID_OFS = 8'hbd;
  localparam logic [7:0] INPUT1_LOS_COUNT_LOW_OFS = 8'hbe;
  // field positions
  localparam int INPUT_REF_OFF0_BIT = 0;
  localparam int INPUT_REF_OFF1_BIT = 1;
  localparam int ANALOG_CAL_RESET_BIT = 0;
  localparam int DIGITAL_LOOP_OFF_BIT = 2;
  // widths and reset values
  localparam int LOS_COUNT_W = 17;
  localparam int NUM_INPUTS = 2;
  localparam int NUM_OUTPUTS = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [16:0] LOS_COUNT_RESET = 17'h1ffff;
  localparam logic [16:0] LOS_COUNT_MIN = 17'h00003;
  // monitor states
  typedef enum logic [2:0]
  {
    PDIM_IDLE = 3'b001,
    PDIM_WATCH = 3'b010,
    PDIM_MISSED = 3'b100
  } pdim_mon_state_t;
endpackage

// File: hdl/pdim_los_monitor.sv
// pdim_los_monitor: one input reference loss-of-signal watcher.
// assumes refEdge is a one-cycle pulse already synchronised to clk.
`timescale 1ns/1ps
module pdim_los_monitor
  import pdim_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic monTick,
  input wire logic enable,
  input wire logic refEdge,
  input wire logic [LOS_COUNT_W-1:0] periodCount,
  output logic missed
);
  pdim_mon_state_t state_q, state_d;
  logic [LOS_COUNT_W-1:0] cnt_q, cnt_d;

  // count monitor periods since last edge
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      PDIM_IDLE:
      begin
        cnt_d = '0;
        if (enable)
          state_d = PDIM_WATCH;
      end
      PDIM_WATCH, PDIM_MISSED:
      begin
        if (!enable)
        begin
          state_d = PDIM_IDLE;
          cnt_d = '0;
        end
        else if (refEdge)
        begin
          state_d = PDIM_WATCH;
          cnt_d = '0;
        end
        else if (monTick && state_q == PDIM_WATCH)
        begin
          cnt_d = cnt_q + 17'h00001;
          if (cnt_d >= periodCount)
            state_d = PDIM_MISSED;
        end
      end
      default:
      begin
        state_d = PDIM_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= PDIM_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign missed = (state_q == PDIM_MISSED);

  a_alarm_after_count: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDIM_WATCH && enable && !refEdge && monTick && cnt_q + 17'h1 >= periodCount)
    |=> missed)
    else $error("alarm not raised at count expiry");
  a_edge_clears_alarm: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && refEdge) |=> !missed && cnt_q == '0)
    else $error("edge did not clear monitor");
  c_missed: cover property (@(posedge clk) disable iff (!rst_n) $rose(missed));
endmodule

// File: hdl/pdim_regs.sv
// pdim_regs: power-down and input-monitor register bank with LOS watchers.
// assumes a serial-port front end giving one-cycle byte read/write strobes
// on clk; reference clock edges and monitor tick arrive from other domains.
`timescale 1ns/1ps
// Functional notes
// - 17-bit missing-edge period count per input
// - expired count declares reference missed, soft alarm
// - digital loop off resets zero, one disables
// - reserved bit reads undefined, return zero here
module pdim_regs
  import pdim_pkg::*;
#(
  parameter int NOUT = NUM_OUTPUTS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regAck,
  input wire logic monTickPin,
  input wire logic [NUM_INPUTS-1:0] refPin,
  output logic [NUM_INPUTS-1:0] inputRefOff,
  output logic [NOUT-1:0] outputOff,
  output logic [NOUT-1:0] outputDrvEn,
  output logic digitalLoopOff,
  output logic analogCalReset,
  output logic [NUM_INPUTS-1:0] softAlarm
);
  logic [NUM_INPUTS-1:0] inOff_q, inOff_d;
  logic [NOUT-1:0] outOff_q, outOff_d;
  logic loopOff_q, loopOff_d;
  logic analog_cal_reset_q, analog_cal_reset_d;
  logic [LOS_COUNT_W-1:0] losCnt_q [NUM_INPUTS];
  logic [LOS_COUNT_W-1:0] losCnt_d [NUM_INPUTS];
  logic [7:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [NUM_INPUTS:0] pinMeta_q, pinSync_q, pinLast_q;
  logic [NUM_INPUTS-1:0] refEdge;
  logic monTick;

  // high/mid/low byte of a LOS count for offset match
  function automatic logic [1:0] los_slot(input logic [7:0] a, input logic [7:0] hi);
    if (a == hi)
      los_slot = 2'h2;
    else if (a == hi + 8'h01)
      los_slot = 2'h1;
    else if (a == hi + 8'h02)
      los_slot = 2'h0;
    else
      los_slot = 2'h3;
  endfunction

  function automatic logic [7:0] los_hi(input int idx);
    los_hi = (idx == 0) ? INPUT0_LOS_COUNT_HIGH_OFS : INPUT1_LOS_COUNT_HIGH_OFS;
  endfunction

  // register writes and reads
  always_comb
  begin
    inOff_d = inOff_q;
    outOff_d = outOff_q;
    loopOff_d = loopOff_q;
    analog_cal_reset_d = analog_cal_reset_q;
    losCnt_d = losCnt_q;
    rdata_d = rdata_q;
    ack_d = regWrite | regRead;
    if (regWrite)
    begin
      case (regAddr)
        INPUT_REFERENCE_DISABLE_OFS:
          inOff_d = {regWdata[INPUT_REF_OFF1_BIT], regWdata[INPUT_REF_OFF0_BIT]};
        OUTPUT_DRIVER_DISABLE_OFS:
          outOff_d = regWdata[NOUT-1:0];
        PLL_BLOCK_DISABLE_OFS:
        begin
          loopOff_d = regWdata[DIGITAL_LOOP_OFF_BIT];
          analog_cal_reset_d = regWdata[ANALOG_CAL_RESET_BIT];
        end
        default:
          ;
      endcase
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        case (los_slot(regAddr, los_hi(i)))
          2'h2: losCnt_d[i][16] = regWdata[0];
          2'h1: losCnt_d[i][15:8] = regWdata;
          2'h0: losCnt_d[i][7:0] = regWdata;
          default:
            ;
        endcase
      end
    end
    if (regRead)
    begin
      // reserved bits read as zero
      case (regAddr)
        INPUT_REFERENCE_DISABLE_OFS: rdata_d = {6'h00, inOff_q};
        OUTPUT_DRIVER_DISABLE_OFS: rdata_d = 8'(outOff_q);
        PLL_BLOCK_DISABLE_OFS: rdata_d = {5'h00, loopOff_q, 1'b0, analog_cal_reset_q};
        default: rdata_d = REG_RESET;
      endcase
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        case (los_slot(regAddr, los_hi(i)))
          2'h2: rdata_d = {7'h00, losCnt_q[i][16]};
          2'h1: rdata_d = losCnt_q[i][15:8];
          2'h0: rdata_d = losCnt_q[i][7:0];
          default:
            ;
        endcase
      end
    end
  end

  // register state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      inOff_q <= '0;
      outOff_q <= '0;
      loopOff_q <= 1'b0;
      analog_cal_reset_q <= 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++)
        losCnt_q[i] <= LOS_COUNT_RESET;
      rdata_q <= REG_RESET;
      ack_q <= 1'b0;
    end
    else
    begin
      inOff_q <= inOff_d;
      outOff_q <= outOff_d;
      loopOff_q <= loopOff_d;
      analog_cal_reset_q <= analog_cal_reset_d;
      losCnt_q <= losCnt_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // two-flop sync of reference pins and monitor tick, then edge detect
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinLast_q <= '0;
    end
    else
    begin
      pinMeta_q <= {monTickPin, refPin};
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end

  assign refEdge = pinSync_q[NUM_INPUTS-1:0] & ~pinLast_q[NUM_INPUTS-1:0];
  assign monTick = pinSync_q[NUM_INPUTS] & ~pinLast_q[NUM_INPUTS];

  // one watcher per input reference
  for (genvar g = 0; g < NUM_INPUTS; g++)
  begin : g_mon
    pdim_los_monitor u_mon
    (
      .clk(clk),
      .rst_n(rst_n),
      .monTick(monTick),
      .enable(!inOff_q[g]),
      .refEdge(refEdge[g]),
      .periodCount(losCnt_q[g]),
      .missed(softAlarm[g])
    );
  end

  // control outputs
  assign regRdata = rdata_q;
  assign regAck = ack_q;
  assign inputRefOff = inOff_q;
  assign outputOff = outOff_q;
  assign outputDrvEn = ~outOff_q;
  assign digitalLoopOff = loopOff_q;
  assign analogCalReset = analog_cal_reset_q;

  a_loop_off_write: assert property (@(posedge clk) disable iff (!rst_n)
    (regWrite && regAddr == PLL_BLOCK_DISABLE_OFS) |=>
    digitalLoopOff == $past(regWdata[DIGITAL_LOOP_OFF_BIT]))
    else $error("digital loop off not written");
  a_loop_off_reset: assert property (@(posedge clk)
    $past(!rst_n) |-> !digitalLoopOff)
    else $error("digital loop off not zero after reset");
  a_output_tristate: assert property (@(posedge clk) disable iff (!rst_n)
    (regWrite && regAddr == OUTPUT_DRIVER_DISABLE_OFS) |=>
    outputDrvEn == ~$past(regWdata[NOUT-1:0]))
    else $error("output driver enable mismatch");
  a_los_low_write: assert property (@(posedge clk) disable iff (!rst_n)
    (regWrite && regAddr == INPUT0_LOS_COUNT_LOW_OFS) |=>
    losCnt_q[0][7:0] == $past(regWdata))
    else $error("los count low byte not stored");
  a_los_high_read: assert property (@(posedge clk) disable iff (!rst_n)
    (regRead && regAddr == INPUT1_LOS_COUNT_HIGH_OFS) |=>
    regRdata == {7'h00, $past(losCnt_q[1][16])} && regAck)
    else $error("los high byte read wrong");
  a_off_no_alarm: assert property (@(posedge clk) disable iff (!rst_n)
    inOff_q[0] ##1 inOff_q[0] |-> !softAlarm[0])
    else $error("alarm on disabled input");
  c_out_off: cover property (@(posedge clk) disable iff (!rst_n) outputOff != '0);
  c_loop_off: cover property (@(posedge clk) disable iff (!rst_n) $rose(digitalLoopOff));
  c_alarm1: cover property (@(posedge clk) disable iff (!rst_n) $rose(softAlarm[1]));
endmodule

// File: tb/pdim_host.sv
// pdim_host: host model issuing byte writes and reads to the bank
// assumes strobes taken at posedge clk, answer one cycle later
`timescale 1ns/1ps
module pdim_host (
  input wire logic clk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regAck
);
  int nAckMiss = 0;
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // defined bits of each register, reserved ones are zero
  function automatic logic [7:0] rsvdMask(input logic [7:0] a);
    case (a)
      8'hb5: return 8'h03;
      8'hb8: return 8'h05;
      8'hb9, 8'hbc: return 8'h01;
      default: return 8'hff;
    endcase
  endfunction
  // one strobe, then wait for the acknowledge under a bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    @(negedge clk);
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWdata = d & rsvdMask(a);
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    n = 0;
    while (regAck !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    if (n != 0 || regAck !== 1'b1)
      nAckMiss++; // answer must stand one cycle after the strobe
    q = regRdata;
  endtask
endmodule

// File: tb/tb_power_down_input_monitor_regs.sv
// tb_power_down_input_monitor_regs: register and loss-of-signal checks
// assumes pdim_host drives the byte strobes; pins toggled by the bench
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_power_down_input_monitor_regs
  import pdim_pkg::*;
;
  logic clk, rst_n, regWrite, regRead, regAck, monTickPin;
  logic digitalLoopOff, analogCalReset;
  logic [7:0] regAddr, regWdata, regRdata, q, outputOff, outputDrvEn, expv;
  logic [1:0] refPin, inputRefOff, softAlarm;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] cnt [3] = '{8'h01, 8'h23, 8'h45};
  pdim_host host_u (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck));
  pdim_regs dut_u (.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
    .monTickPin(monTickPin), .refPin(refPin), .inputRefOff(inputRefOff),
    .outputOff(outputOff), .outputDrvEn(outputDrvEn), .digitalLoopOff(digitalLoopOff),
    .analogCalReset(analogCalReset), .softAlarm(softAlarm));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pin pulse: high four cycles, low four cycles
  task automatic pulse(input int which);
    @(negedge clk);
    if (which == 2) monTickPin = 1'b1; else refPin[which] = 1'b1;
    repeat (4) @(negedge clk);
    monTickPin = 1'b0;
    refPin = 2'b00;
    repeat (4) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    monTickPin = 1'b0;
    refPin = 2'b00;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 8'hb5; a <= 8'hbe; a++)
    begin
      host_u.xfer(1'b0, 8'(a), 8'h00, q);
      // expected reset byte of each register
      case (a)
        8'hb9, 8'hbc: expv = 8'(LOS_COUNT_RESET[16]);
        8'hba, 8'hbd: expv = LOS_COUNT_RESET[15:8];
        8'hbb, 8'hbe: expv = LOS_COUNT_RESET[7:0];
        default: expv = REG_RESET;
      endcase
      `CHK("reset", expv & host_u.rsvdMask(8'(a)), q & host_u.rsvdMask(8'(a)))
    end
    `CHK("drvEn", 8'hff, outputDrvEn)
    `CHK("loopOff", 1'b0, digitalLoopOff)
    host_u.xfer(1'b1, OUTPUT_DRIVER_DISABLE_OFS, 8'ha5, q);
    `CHK("outOff", 8'ha5, outputOff)
    `CHK("drvEn", 8'h5a, outputDrvEn)
    host_u.xfer(1'b1, PLL_BLOCK_DISABLE_OFS, 8'h05, q);
    `CHK("loopOff", 1'b1, digitalLoopOff)
    `CHK("analog_cal_reset", 1'b1, analogCalReset)
    host_u.xfer(1'b0, PLL_BLOCK_DISABLE_OFS, 8'h00, q);
    `CHK("b8", 8'h05, q & 8'h05)
    host_u.xfer(1'b1, INPUT_REFERENCE_DISABLE_OFS, 8'h02, q);
    `CHK("refOff", 2'b10, inputRefOff)
    // full 17-bit count on input 0, then read back
    for (int i = 0; i < 3; i++) host_u.xfer(1'b1, 8'(8'hb9 + i), cnt[i], q);
    for (int i = 0; i < 3; i++)
    begin
      host_u.xfer(1'b0, 8'(8'hb9 + i), 8'h00, q);
      `CHK("count", cnt[i], q & host_u.rsvdMask(8'(8'hb9 + i)))
    end
    // minimum legal count of three
    host_u.xfer(1'b1, INPUT0_LOS_COUNT_HIGH_OFS, 8'h00, q);
    host_u.xfer(1'b1, INPUT0_LOS_COUNT_MID_OFS, 8'h00, q);
    host_u.xfer(1'b1, INPUT0_LOS_COUNT_LOW_OFS, 8'h03, q);
    pulse(0);
    pulse(2);
    pulse(2);
    `CHK("alarm", 2'b00, softAlarm)
    pulse(2);
    `CHK("alarm", 2'b01, softAlarm)
    pulse(0);
    `CHK("alarm", 2'b00, softAlarm)
    // disable input 0, then arm input 1 with the minimum count
    host_u.xfer(1'b1, INPUT_REFERENCE_DISABLE_OFS, 8'h01, q);
    `CHK("refOff", 2'b01, inputRefOff)
    repeat (3) pulse(2);
    `CHK("alarm", 2'b00, softAlarm)
    host_u.xfer(1'b1, INPUT1_LOS_COUNT_HIGH_OFS, 8'h00, q);
    host_u.xfer(1'b1, INPUT1_LOS_COUNT_MID_OFS, 8'h00, q);
    host_u.xfer(1'b1, INPUT1_LOS_COUNT_LOW_OFS, LOS_COUNT_MIN[7:0], q);
    pulse(1);
    repeat (2) pulse(2);
    `CHK("alarm", 2'b00, softAlarm)
    pulse(2);
    `CHK("alarm", 2'b10, softAlarm)
    // mid-run reset puts controls and counts back
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK("loopOff", 1'b0, digitalLoopOff)
    `CHK("drvEn", 8'hff, outputDrvEn)
    `CHK("alarm", 2'b00, softAlarm)
    host_u.xfer(1'b0, INPUT0_LOS_COUNT_LOW_OFS, 8'h00, q);
    `CHK("countRst", LOS_COUNT_RESET[7:0], q)
    `CHK("ackMiss", 0, host_u.nAckMiss)
    stop_test();
  end
endmodule
